/* pkg/prtc_pkg.sv */
package prtc_pkg;

    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam int PRE_W  = 18;

    // register offsets on the plain register port
    localparam logic [ADDR_W-1:0] OFF_STATUS_CONTROL = 2'h0;
    localparam logic [ADDR_W-1:0] OFF_CURRENT_COUNT  = 2'h1;
    localparam logic [ADDR_W-1:0] OFF_MODULO_LIMIT   = 2'h2;

    // status_and_control field positions
    localparam int BIT_MATCH_FLAG = 7;
    localparam int BIT_SRC_HI     = 6;
    localparam int BIT_SRC_LO     = 5;
    localparam int BIT_IRQ_EN     = 4;
    localparam int BIT_DIV_HI     = 3;
    localparam int BIT_DIV_LO     = 0;

    // source_select encodings (1x selects internal_ref_clock)
    localparam logic [1:0] SRC_LOW_POWER_OSC = 2'h0;
    localparam logic [1:0] SRC_EXTERNAL_REF  = 2'h1;

    localparam logic [DATA_W-1:0] RESET_BYTE  = 8'h00;
    localparam logic [3:0]        DIV_OFF     = 4'h0;
    localparam logic [PRE_W-1:0]  PRE_ZERO    = 18'h00000;
    localparam logic [PRE_W-1:0]  PRE_ONE     = 18'h00001;

    typedef struct packed {
        logic       match_flag;
        logic [1:0] source_select;
        logic       match_irq_enable;
        logic [3:0] divider_select;
    } prtc_ctrl_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } prtc_bus_t;

    // divide ratio of the prescaler; 0 for off
    function automatic logic [PRE_W-1:0] divide_ratio(
        input logic       decimal_set,
        input logic [3:0] sel
    );
        logic [PRE_W-1:0] r;
        r = PRE_ZERO;
        if (!decimal_set) begin
            unique case (sel)
                4'h0: r = 18'h00000;
                4'h1: r = 18'h00008;
                4'h2: r = 18'h00020;
                4'h3: r = 18'h00040;
                4'h4: r = 18'h00080;
                4'h5: r = 18'h00100;
                4'h6: r = 18'h00200;
                4'h7: r = 18'h00400;
                4'h8: r = 18'h00001;
                4'h9: r = 18'h00002;
                4'hA: r = 18'h00004;
                4'hB: r = 18'h0000A;
                4'hC: r = 18'h00010;
                4'hD: r = 18'h00064;
                4'hE: r = 18'h001F4;
                4'hF: r = 18'h003E8;
            endcase
        end else begin
            unique case (sel)
                4'h0: r = 18'h00000;
                4'h1: r = 18'h00400;
                4'h2: r = 18'h00800;
                4'h3: r = 18'h01000;
                4'h4: r = 18'h02000;
                4'h5: r = 18'h04000;
                4'h6: r = 18'h08000;
                4'h7: r = 18'h10000;
                4'h8: r = 18'h003E8;
                4'h9: r = 18'h007D0;
                4'hA: r = 18'h01388;
                4'hB: r = 18'h02710;
                4'hC: r = 18'h04E20;
                4'hD: r = 18'h0C350;
                4'hE: r = 18'h186A0;
                4'hF: r = 18'h30D40;
            endcase
        end
        return r;
    endfunction

endpackage

/* design/prtc_top.sv */
//Contract
//- count register is read-only, writes ignored
//- set match_flag on the tick after count reaches modulo
//- writing one clears flag; reset clears
//- source_select picks prescaler clock input
//- source change clears prescaler and count
//- match_irq_enable gates interrupt request
//- divider_select zero turns prescaler off
//- binary divide table when source low bit zero
//- decimal divide table when source low bit one
//- divider change clears prescaler and count
//- on match count returns to zero, flag set
//- modulo zero flags every prescaler edge
//- modulo write clears prescaler and count
//- reset zeroes modulo and count
//- unchanged select writes leave counter alone
//- count advances at prescaler output rate
//- flag sets on modulo to zero transition
//- debug halt suspends counting, resumes after
module prtc_top
    import prtc_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              low_power_osc,
    input  wire logic              external_ref_clock,
    input  wire logic              internal_ref_clock,
    input  wire logic              debug_halt,
    output logic                   irq
);

    prtc_bus_t        bus;
    prtc_ctrl_t       ctrl;
    prtc_ctrl_t       next_ctrl;
    prtc_ctrl_t       wr_ctrl;
    logic [DATA_W-1:0] count_value;
    logic [DATA_W-1:0] next_count;
    logic [DATA_W-1:0] modulo_limit;
    logic [DATA_W-1:0] next_modulo;
    logic [PRE_W-1:0]  prescale;
    logic [PRE_W-1:0]  next_prescale;
    logic [DATA_W-1:0] next_rdata;
    logic              src_prev;
    logic              next_irq;

    wire logic             src_level;
    wire logic             src_rise;
    wire logic             wr_ctrl_hit;
    wire logic             wr_mod_hit;
    wire logic             sel_changed;
    wire logic             restart;
    wire logic [PRE_W-1:0] ratio;
    wire logic             prescaler_on;
    wire logic             tick;
    wire logic             at_match;
    wire logic             flag_set;
    wire logic             flag_clr;

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign wr_ctrl = prtc_ctrl_t'(bus.wdata);

    assign src_level = (ctrl.source_select == SRC_LOW_POWER_OSC)
                     ? low_power_osc
                     : (ctrl.source_select == SRC_EXTERNAL_REF)
                     ? external_ref_clock
                     : internal_ref_clock;
    // sources are slow against clock, so one stage of history finds edges
    assign src_rise = src_level && !src_prev;

    assign wr_ctrl_hit = bus.wr && (bus.addr == OFF_STATUS_CONTROL);
    assign wr_mod_hit  = bus.wr && (bus.addr == OFF_MODULO_LIMIT);
    // only a different select value restarts the chain; any modulo write restarts it too
    assign sel_changed = wr_ctrl_hit &&
        ((wr_ctrl.source_select != ctrl.source_select) ||
         (wr_ctrl.divider_select != ctrl.divider_select));
    assign restart = sel_changed || wr_mod_hit;

    assign ratio = divide_ratio(ctrl.source_select[0],
                                ctrl.divider_select);
    assign prescaler_on = (ctrl.divider_select != DIV_OFF);
    // counting freezes while debug holds the core
    assign tick = prescaler_on && src_rise && !debug_halt && !restart &&
                  (prescale == ratio - PRE_ONE);
    assign at_match = (count_value == modulo_limit);
    assign flag_set = tick && at_match;
    assign flag_clr = wr_ctrl_hit && wr_ctrl.match_flag;

    always_comb begin
        next_prescale = prescale;
        if (restart || !prescaler_on) begin
            next_prescale = PRE_ZERO;
        end else if (src_rise && !debug_halt) begin
            next_prescale = tick ? PRE_ZERO : prescale + PRE_ONE;
        end
    end

    always_comb begin
        next_count = count_value;
        if (restart) begin
            next_count = RESET_BYTE;
        end else if (tick) begin
            next_count = at_match ? RESET_BYTE
                                  : count_value + 8'h01;
        end
    end

    always_comb begin
        next_ctrl = ctrl;
        if (wr_ctrl_hit) begin
            next_ctrl.source_select    = wr_ctrl.source_select;
            next_ctrl.match_irq_enable = wr_ctrl.match_irq_enable;
            next_ctrl.divider_select   = wr_ctrl.divider_select;
        end
        // a match in the clearing cycle keeps the flag up
        if (flag_set) begin
            next_ctrl.match_flag = 1'b1;
        end else if (flag_clr) begin
            next_ctrl.match_flag = 1'b0;
        end
    end

    assign next_modulo = wr_mod_hit ? bus.wdata : modulo_limit;
    assign next_irq = next_ctrl.match_flag &&
                      next_ctrl.match_irq_enable;

    // writes to the count offset fall through the decode untouched
    always_comb begin
        next_rdata = RESET_BYTE;
        if (bus.rd) begin
            unique case (bus.addr)
                OFF_STATUS_CONTROL: next_rdata = ctrl;
                OFF_CURRENT_COUNT:  next_rdata = count_value;
                OFF_MODULO_LIMIT:   next_rdata = modulo_limit;
                default:            next_rdata = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ctrl         <= prtc_ctrl_t'(RESET_BYTE);
            count_value  <= RESET_BYTE;
            modulo_limit <= RESET_BYTE;
            prescale     <= PRE_ZERO;
            src_prev     <= 1'b0;
            rdata        <= RESET_BYTE;
            irq          <= 1'b0;
        end else begin
            ctrl         <= next_ctrl;
            count_value  <= next_count;
            modulo_limit <= next_modulo;
            prescale     <= next_prescale;
            src_prev     <= src_level;
            rdata        <= next_rdata;
            irq          <= next_irq;
        end
    end

endmodule // prtc_top

/* sim/prtc_checker.sv */
module prtc_checker
    import prtc_pkg::*;
(
    input wire logic              clock,
    input wire logic              rstn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_mod_wr;
        wr && addr == OFF_MODULO_LIMIT;
    endsequence
    // a read two edges after the write, with no other write in between
    sequence s_rd_after(a);
        ##1 !wr ##1 rd && addr == a;
    endsequence
    property p_idle; !rd |=> rdata == RESET_BYTE; endproperty
    property p_clr; wr && addr == 0 && wdata[7] |=> !irq; endproperty
    property p_gate; wr && addr == 0 && !wdata[4] |=> !irq; endproperty
    property p_mod;
        s_mod_wr ##0 s_rd_after(OFF_MODULO_LIMIT) |=> rdata == $past(wdata, 3);
    endproperty
    property p_zero;
        s_mod_wr ##0 s_rd_after(OFF_CURRENT_COUNT) |=> rdata == RESET_BYTE;
    endproperty
    property p_rst; $rose(rstn) |-> !irq; endproperty
    property p_both; rd && addr == 0 && irq |=> rdata[7] && rdata[4]; endproperty
    // a reset edge also drops irq, so it is excused here
    property p_hold;
        $fell(irq) |-> $past(wr && addr == 0) || !$past(rstn);
    endproperty
    a_idle: assert property (p_idle) else $error("rdata not idle");
    a_clr: assert property (p_clr) else $error("irq not cleared");
    a_gate: assert property (p_gate) else $error("irq not gated");
    a_mod: assert property (p_mod) else $error("modulo readback");
    a_zero: assert property (p_zero) else $error("count not zeroed");
    a_rst: assert property (p_rst) else $error("irq after reset");
    a_both: assert property (p_both) else $error("irq without bits");
    a_hold: assert property (p_hold) else $error("irq dropped");
endmodule // prtc_checker

bind prtc_top prtc_checker prtc_checker_inst (.clock(clock), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

/* sim/prtc_top_test.sv */
module prtc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import prtc_pkg::*;
    logic              clock;
    logic              rstn;
    logic              wr;
    logic              rd;
    logic              debug_halt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] got;
    logic [2:0]        src;
    logic              irq;
    int                mismatches;
    int                checks;
    prtc_top prtc_top_inst (.clock(clock), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .low_power_osc(src[0]), .external_ref_clock(src[1]),
        .internal_ref_clock(src[2]), .debug_halt(debug_halt), .irq(irq));
    initial begin
        clock = 0;
        forever #10 clock = ~clock;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrt(logic [1:0] a, logic [7:0] d);
        @(posedge clock);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 0;
    endtask
    task automatic chk(logic [1:0] a, logic [7:0] e);
        @(posedge clock);
        rd <= 1;
        addr <= a;
        @(posedge clock);
        rd <= 0;
        #1 got = rdata;
        cmp($sformatf("reg %0d", a), e, got);
    endtask
    // sources are idle low between bursts, so a switch makes no false edge
    task automatic edges(int n, int i);
        repeat (n) begin
            src[i] <= 1;
            repeat (2) @(posedge clock);
            src[i] <= 0;
            repeat (2) @(posedge clock);
        end
    endtask
    initial begin
        #400000;
        mismatches++;
        close_out();
    end
    initial begin
        {rstn, wr, rd, debug_halt, addr, wdata, src} = '0;
        repeat (4) @(posedge clock);
        rstn <= 1;
        chk(0, 8'h00);
        chk(2, 8'h00);
        wrt(1, 8'h5A);
        chk(1, 8'h00);
        chk(3, 8'h00);
        edges(2, 0);
        chk(1, 8'h00);
        wrt(2, 8'h02);
        chk(2, 8'h02);
        wrt(0, 8'h18);
        edges(2, 0);
        chk(1, 8'h02);
        cmp("irq", 8'h00, {7'h0, irq});
        edges(1, 0);
        chk(1, 8'h00);
        chk(0, 8'h98);
        cmp("irq", 8'h01, {7'h0, irq});
        wrt(0, 8'h18);
        chk(0, 8'h98);
        wrt(0, 8'h98);
        chk(0, 8'h18);
        edges(1, 1);
        edges(1, 0);
        wrt(0, 8'h18);
        chk(1, 8'h01);
        wrt(0, 8'h19);
        chk(1, 8'h00);
        edges(3, 0);
        chk(1, 8'h01);
        wrt(0, 8'h38);
        chk(1, 8'h00);
        edges(999, 1);
        chk(1, 8'h00);
        edges(1, 1);
        chk(1, 8'h01);
        wrt(0, 8'h58);
        edges(1, 2);
        chk(1, 8'h01);
        debug_halt <= 1;
        edges(1, 2);
        chk(1, 8'h01);
        debug_halt <= 0;
        edges(1, 2);
        chk(1, 8'h02);
        wrt(2, 8'h00);
        chk(1, 8'h00);
        edges(1, 2);
        chk(0, 8'hD8);
        wrt(0, 8'hD8);
        edges(1, 2);
        chk(0, 8'hD8);
        wrt(0, 8'h48);
        chk(0, 8'hC8);
        cmp("irq", 8'h00, {7'h0, irq});
        close_out();
    end
endmodule // prtc_top_test
